//--- rtl/dcst_defs.svh
// Register offsets, field positions, reset values and the address decode width of the DMA completion status tracker.
`ifndef DCST_DEFS_SVH
`define DCST_DEFS_SVH
`define DCST_CH0_STATE_OFS    12'h504
`define DCST_CH0_SRC_HIGH_OFS 12'h508
`define DCST_CH1_STATE_OFS    12'h584
`define DCST_CH1_SRC_HIGH_OFS 12'h588
`define DCST_IRQ_STATUS_OFS   12'h600
`define DCST_IRQ_MASK_OFS     12'h604
`define DCST_CTRL_OFS         12'h608
`define DCST_FAULT_BIT        28
`define DCST_CANCEL_BIT       27
`define DCST_HALT_BIT         26
`define DCST_COMPLETE_BIT     25
`define DCST_ACTIVE_BIT       24
`define DCST_ORIGIN_BIT       20
`define DCST_KIND_HI          17
`define DCST_KIND_LO          16
`define DCST_CTRL_LAUNCH_LO   0
`define DCST_CTRL_CANCEL_LO   2
`define DCST_CTRL_HALT_LO     4
`define DCST_REG_RESET        32'h00000000
`define DCST_ADDR_DEC_BITS    12
`endif

//--- rtl/dcst_pkg.sv
// Types shared by the DMA completion status tracker.
package dcst_pkg;
    typedef enum logic [1:0] {
        DCST_IDLE  = 2'b00,
        DCST_RUN   = 2'b01,
        DCST_CLOSE = 2'b10
    } dcst_state_e;

    typedef struct packed {
        logic        start;
        logic        finish;
        logic        fault;
        logic        fault_pci;
        logic [1:0]  fault_kind;
        logic        cancel_done;
        logic        halt_done;
        logic        list_mode;
        logic        src_valid;
        logic [31:0] src_high;
    } dcst_mover_s;

    typedef struct packed {
        logic       fault;
        logic       cancel;
        logic       halt;
        logic       complete;
        logic       active;
        logic       origin;
        logic [1:0] kind;
    } dcst_status_s;

    typedef struct packed {
        logic launch;
        logic cancel;
        logic halt;
    } dcst_req_s;
endpackage

//--- rtl/dcst_top.sv
// AHB-Lite slave holding two DMA channels' busy and completion status and source address.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "dcst_defs.svh"

// Overview of operation
// [RULE_01] On start after launch, set active and clear done, halt, cancel, fault.
// [RULE_02] Active stays set and completion flags stay clear during the transaction.
// [RULE_03] On finish active clears and exactly one completion flag sets.
// [RULE_04] Interrupt to exception unit whenever active falls.
// [RULE_05] Simultaneous outcomes: fault, then cancel, then halt, then done.
// [RULE_06] First outcome wins; a fault before halt or cancel reports fault only.
// [RULE_07] Fault flag sets on error from either PCI/X bus or VMEbus.
// [RULE_08] Cancel flag needs cancel request, no fault, and cancel effective before completion.
// [RULE_09] Halt flag needs halt request, no fault, no cancel, effective before completion.
// [RULE_10] Done flag needs no fault and no effective cancel or halt.
// [RULE_11] Active reads one while processing, zero when idle.
// [RULE_12] Origin one means PCI/X fault, zero VMEbus; PCI/X kind 00b is bus error.
// [RULE_13] VMEbus fault kind is passed as the two-bit code of the mover.
// [RULE_14] Read-only register gives source address bits 63 to 32.
// [RULE_15] After a fill read error the source address holds the failing address; the code keeps the last address before the fault.
// [RULE_16] Software launches by writing one to launch; launch reads zero.
// [RULE_17] Halt requests are honoured only for descriptor-list transactions.
// [RULE_18] Each channel has its own status and address registers, reset to zero.
module dcst_top #(
    parameter int NUM_CH = 2
) (
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    input  wire logic                                hsel,
    input  wire logic [31:0]                         haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output logic      [31:0]                         hrdata,
    output logic                                     hreadyout,
    output logic                                     hresp,
    input  wire dcst_pkg::dcst_mover_s [NUM_CH-1:0]  mover,
    output dcst_pkg::dcst_req_s        [NUM_CH-1:0]  req,
    output logic      [NUM_CH-1:0]                   exc_irq,
    output logic                                     irq
);
    import dcst_pkg::*;

    logic        [NUM_CH-1:0]  nxt_req_launch;
    logic        [NUM_CH-1:0]  nxt_req_cancel;
    logic        [NUM_CH-1:0]  nxt_req_halt;
    dcst_req_s   [NUM_CH-1:0]  req_ff;
    logic        [NUM_CH-1:0]  exc_irq_ff;
    dcst_status_s [NUM_CH-1:0] stat_ff;
    logic        [31:0]        src_ff [NUM_CH];
    dcst_state_e [NUM_CH-1:0]  state_ff;
    logic        [NUM_CH-1:0]  cancel_pend_ff;
    logic        [NUM_CH-1:0]  halt_pend_ff;
    logic        [NUM_CH-1:0]  fault_seen_ff;
    logic        [NUM_CH-1:0]  irq_stat_ff;
    logic        [NUM_CH-1:0]  irq_mask_ff;
    logic                      irq_ff;
    logic        [31:0]        hrdata_ff;
    logic                      wr_pend_ff;
    logic        [11:0]        wr_addr_ff;
    logic                      rd_stat_ff;

    wire        addr_ok   = hsel & hready & htrans[1];
    wire        rd_go     = addr_ok & ~hwrite;
    wire        wr_go     = addr_ok & hwrite;
    wire [11:0] rd_ofs    = haddr[11:0];
    wire        wr_ctrl   = wr_pend_ff & (wr_addr_ff == `DCST_CTRL_OFS);
    wire        wr_mask   = wr_pend_ff & (wr_addr_ff == `DCST_IRQ_MASK_OFS);
    wire        rd_istat  = rd_go & (rd_ofs == `DCST_IRQ_STATUS_OFS);

    function automatic logic [31:0] pack_state(input dcst_status_s s);
        logic [31:0] w;
        w = `DCST_REG_RESET;
        w[`DCST_FAULT_BIT]    = s.fault;
        w[`DCST_CANCEL_BIT]   = s.cancel;
        w[`DCST_HALT_BIT]     = s.halt;
        w[`DCST_COMPLETE_BIT] = s.complete;
        w[`DCST_ACTIVE_BIT]   = s.active;
        w[`DCST_ORIGIN_BIT]   = s.origin;
        w[`DCST_KIND_HI:`DCST_KIND_LO] = s.kind;
        return w;
    endfunction

    logic [31:0] rd_word;
    always_comb begin
        rd_word = `DCST_REG_RESET;
        unique case (rd_ofs)
            `DCST_CH0_STATE_OFS:    rd_word = pack_state(stat_ff[0]); // RULE_11
            `DCST_CH0_SRC_HIGH_OFS: rd_word = src_ff[0]; // RULE_14
            `DCST_CH1_STATE_OFS:    rd_word = pack_state(stat_ff[NUM_CH-1]);
            `DCST_CH1_SRC_HIGH_OFS: rd_word = src_ff[NUM_CH-1];
            `DCST_IRQ_STATUS_OFS:   rd_word[NUM_CH-1:0] = irq_stat_ff;
            `DCST_IRQ_MASK_OFS:     rd_word[NUM_CH-1:0] = irq_mask_ff;
            default:                rd_word = `DCST_REG_RESET;
        endcase
    end

    // Request bits are one-cycle strobes, so the control word always reads zero.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign nxt_req_launch[g] = wr_ctrl & hwdata[`DCST_CTRL_LAUNCH_LO + g]; // RULE_16
            assign nxt_req_cancel[g] = wr_ctrl & hwdata[`DCST_CTRL_CANCEL_LO + g];
            assign nxt_req_halt[g]   = wr_ctrl & hwdata[`DCST_CTRL_HALT_LO + g];

            wire dcst_mover_s m = mover[g];
            // A cancel outranks a halt, and both are void once a fault is seen.
            wire fault_now  = m.fault | fault_seen_ff[g]; // RULE_06 RULE_07
            wire cancel_ok  = m.cancel_done & cancel_pend_ff[g] & ~fault_now; // RULE_08
            wire halt_ok    = m.halt_done & halt_pend_ff[g] & m.list_mode
                              & ~cancel_pend_ff[g] & ~fault_now; // RULE_09 RULE_17
            wire end_now    = (state_ff[g] == DCST_RUN) & (m.finish | m.fault | cancel_ok | halt_ok);

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    stat_ff[g]        <= '0; // RULE_18
                    src_ff[g]         <= `DCST_REG_RESET;
                    state_ff[g]       <= DCST_IDLE;
                    cancel_pend_ff[g] <= 1'b0;
                    halt_pend_ff[g]   <= 1'b0;
                    fault_seen_ff[g]  <= 1'b0;
                    exc_irq_ff[g]     <= 1'b0;
                end else begin
                    exc_irq_ff[g] <= 1'b0;
                    if (m.src_valid && state_ff[g] == DCST_RUN && !fault_now) begin
                        src_ff[g] <= m.src_high; // RULE_14 RULE_15
                    end
                    unique case (state_ff[g])
                        DCST_IDLE: begin
                            if (m.start) begin
                                stat_ff[g]        <= '0; // RULE_01
                                stat_ff[g].active <= 1'b1;
                                cancel_pend_ff[g] <= 1'b0;
                                halt_pend_ff[g]   <= 1'b0;
                                fault_seen_ff[g]  <= 1'b0;
                                state_ff[g]       <= DCST_RUN;
                            end
                        end
                        DCST_RUN: begin
                            if (req_ff[g].cancel) cancel_pend_ff[g] <= 1'b1;
                            if (req_ff[g].halt) halt_pend_ff[g] <= 1'b1;
                            if (m.fault && !fault_seen_ff[g]) begin
                                fault_seen_ff[g]  <= 1'b1;
                                stat_ff[g].origin <= m.fault_pci; // RULE_12
                                stat_ff[g].kind   <= m.fault_kind; // RULE_13
                            end
                            if (end_now) begin
                                state_ff[g]         <= DCST_CLOSE;
                                stat_ff[g].active   <= 1'b0; // RULE_03 RULE_02
                                stat_ff[g].fault    <= fault_now; // RULE_05
                                stat_ff[g].cancel   <= ~fault_now & cancel_ok;
                                stat_ff[g].halt     <= ~fault_now & ~cancel_ok & halt_ok;
                                stat_ff[g].complete <= ~fault_now & ~cancel_ok & ~halt_ok; // RULE_10
                                exc_irq_ff[g]       <= 1'b1; // RULE_04
                            end
                        end
                        DCST_CLOSE: begin
                            state_ff[g] <= DCST_IDLE;
                        end
                        default: state_ff[g] <= DCST_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // Status bits are sticky; a set in the same cycle as the clearing read wins.
    wire [NUM_CH-1:0] nxt_irq_stat = (rd_stat_ff ? '0 : irq_stat_ff) | exc_irq_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_ff      <= '0;
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff      <= 1'b0;
            hrdata_ff   <= `DCST_REG_RESET;
            wr_pend_ff  <= 1'b0;
            wr_addr_ff  <= '0;
            rd_stat_ff  <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                req_ff[i] <= '{launch: nxt_req_launch[i], cancel: nxt_req_cancel[i], halt: nxt_req_halt[i]};
            end
            irq_stat_ff <= nxt_irq_stat;
            if (wr_mask) irq_mask_ff <= hwdata[NUM_CH-1:0];
            irq_ff     <= |(nxt_irq_stat & (wr_mask ? hwdata[NUM_CH-1:0] : irq_mask_ff));
            wr_pend_ff <= wr_go;
            rd_stat_ff <= rd_istat;
            if (wr_go) wr_addr_ff <= haddr[11:0];
            if (rd_go) hrdata_ff <= rd_word;
        end
    end

    assign req       = req_ff;
    assign exc_irq   = exc_irq_ff;
    assign irq       = irq_ff;
    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
endmodule

//--- test/dcst_assertions.sv
// Concurrent checks on the status tracker's bus, request and close behaviour.
`timescale 1ns/100ps
module dcst_assertions #(parameter int NUM_CH = 2) (
    input wire logic                               ref_clk,
    input wire logic                               resetn,
    input wire logic                               hsel,
    input wire logic [31:0]                        haddr,
    input wire logic [1:0]                         htrans,
    input wire logic                               hwrite,
    input wire logic [31:0]                        hwdata,
    input wire logic                               hready,
    input wire logic [31:0]                        hrdata,
    input wire dcst_pkg::dcst_mover_s [NUM_CH-1:0] mover,
    input wire dcst_pkg::dcst_req_s [NUM_CH-1:0]   req,
    input wire logic [NUM_CH-1:0]                  exc_irq
);
    import dcst_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic        busy_ff;
    logic        ph_ff;
    logic        ph_wr_ff;
    logic [11:0] ph_a_ff;
    // The close cycle already reads idle, so the pulse masks the shadow busy bit.
    wire act0 = busy_ff & ~exc_irq[0];
    wire ev0 = mover[0].finish | mover[0].fault | mover[0].cancel_done | mover[0].halt_done;
    wire rd_st = ph_ff & ~ph_wr_ff & (ph_a_ff == 12'h504 || ph_a_ff == 12'h584);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            ph_ff <= 1'b0;
            ph_wr_ff <= 1'b0;
            ph_a_ff <= 12'h000;
        end else begin
            busy_ff <= mover[0].start | act0;
            ph_ff <= hsel & hready & htrans[1];
            ph_wr_ff <= hwrite;
            ph_a_ff <= haddr[11:0];
        end
    end
    property p_close_irq; exc_irq[0] |-> $past(ev0); endproperty
    a_close_irq: assert property (p_close_irq) else $error("close pulse without cause");
    property p_irq_pulse; exc_irq[0] |=> !exc_irq[0]; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("close pulse too long");
    property p_finish; act0 && mover[0].finish |=> exc_irq[0]; endproperty
    a_finish: assert property (p_finish) else $error("finish did not close");
    property p_fault; act0 && mover[0].fault |=> exc_irq[0]; endproperty
    a_fault: assert property (p_fault) else $error("fault did not close");
    property p_launch; ph_ff && ph_wr_ff && ph_a_ff == 12'h608 && hwdata[0] |=> req[0].launch; endproperty
    a_launch: assert property (p_launch) else $error("launch not requested");
    property p_ctl_zero; ph_ff && !ph_wr_ff && ph_a_ff == 12'h608 |-> hrdata == 32'h00000000; endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("control read not zero");
    property p_busy_rd; ph_ff && !ph_wr_ff && ph_a_ff == 12'h504 |-> hrdata[24] == $past(act0); endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("active flag wrong");
    property p_one_flag; rd_st |-> $onehot0(hrdata[28:25]); endproperty
    a_one_flag: assert property (p_one_flag) else $error("several outcome flags");
    property p_busy_clear; rd_st && hrdata[24] |-> hrdata[28:25] == 4'h0; endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("outcome flag while active");
    property p_halt_list;
        act0 && mover[0].halt_done && !mover[0].list_mode && !(mover[0].finish | mover[0].fault) |=> !exc_irq[0];
    endproperty
    a_halt_list: assert property (p_halt_list) else $error("halt honoured outside list mode");
endmodule
bind dcst_top dcst_assertions #(.NUM_CH(NUM_CH)) u_chk (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .mover(mover), .req(req), .exc_irq(exc_irq));

//--- test/dcst_mover_model.sv
// Data mover stand-in: starts a channel one cycle after its launch request and replays commanded events.
`timescale 1ns/100ps
module dcst_mover_model (
    input wire logic                     ref_clk,
    input wire logic                     resetn,
    input wire dcst_pkg::dcst_req_s [1:0]   req,
    input wire dcst_pkg::dcst_mover_s [1:0] ev,
    output dcst_pkg::dcst_mover_s [1:0]     mover
);
    import dcst_pkg::*;
    logic [1:0] go_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            go_ff <= 2'b00;
        end else begin
            go_ff <= {req[1].launch, req[0].launch};
        end
    end
    // An address that is not flagged valid is scrambled, so a tracker that samples it anyway is caught.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            mover[i] = ev[i];
            mover[i].start = go_ff[i];
            mover[i].src_high = ev[i].src_valid ? ev[i].src_high : ~ev[i].src_high;
        end
    end
endmodule

//--- test/dma_completion_status_tracker_tb.sv
// Self-checking bench of the DMA completion status tracker.
`timescale 1ns/100ps
module dma_completion_status_tracker_tb;
    import dcst_pkg::*;
    typedef struct packed {logic [7:0] ctl; logic lst; logic [6:0] e1; logic [6:0] e2; logic [31:0] exp;} dcst_row_s;
    logic              ref_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              hsel = 1'b1;
    logic              hwrite = 1'b0;
    logic              hreadyout, hresp, irq;
    logic [1:0]        htrans = 2'b00;
    logic [1:0]        exc_irq;
    logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    dcst_mover_s [1:0] ev = '0;
    dcst_mover_s [1:0] mover;
    dcst_req_s [1:0]   req;
    int                miscompares = 0;
    int                n_tests = 0;
    logic [11:0]       ra [8] = '{12'h504, 12'h508, 12'h584, 12'h588, 12'h600, 12'h604, 12'h608, 12'h700};
    // Event code: finish, fault, origin, kind[1:0], cancel taken, halt taken.
    dcst_row_s rows [13] = '{'{8'h00, 1'b0, 7'h40, 7'h00, 32'h02000000}, '{8'h00, 1'b0, 7'h30, 7'h00, 32'h10100000},
        '{8'h00, 1'b0, 7'h24, 7'h00, 32'h10010000}, '{8'h00, 1'b0, 7'h28, 7'h00, 32'h10020000},
        '{8'h00, 1'b0, 7'h2c, 7'h00, 32'h10030000}, '{8'h04, 1'b0, 7'h02, 7'h00, 32'h08000000},
        '{8'h10, 1'b1, 7'h01, 7'h00, 32'h04000000}, '{8'h04, 1'b0, 7'h22, 7'h00, 32'h10000000},
        '{8'h14, 1'b1, 7'h03, 7'h00, 32'h08000000}, '{8'h10, 1'b0, 7'h01, 7'h40, 32'h02000000},
        '{8'h00, 1'b0, 7'h02, 7'h40, 32'h02000000}, '{8'h04, 1'b0, 7'h20, 7'h02, 32'h10000000},
        '{8'h10, 1'b1, 7'h41, 7'h00, 32'h04000000}};
    dcst_top #(.NUM_CH(2)) dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .mover(mover), .req(req), .exc_irq(exc_irq), .irq(irq));
    dcst_mover_model u_mdl (.ref_clk(ref_clk), .resetn(resetn), .req(req), .ev(ev), .mover(mover));
    function automatic dcst_mover_s mk(input logic [6:0] c, input logic l);
        mk = '0;
        {mk.finish, mk.fault, mk.fault_pci, mk.fault_kind, mk.cancel_done, mk.halt_done} = c;
        mk.list_mode = l;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic pulse(input int ch, input logic [6:0] c, input logic l);
        @(posedge ref_clk);
        ev[ch] <= mk(c, l);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        repeat (6000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        foreach (ra[i]) rd(ra[i], 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        xfer(1'b1, 12'h604, 32'h1);
        foreach (rows[i]) begin
            xfer(1'b1, 12'h608, 32'h1);
            repeat (3) @(posedge ref_clk);
            rd(12'h504, 32'h01000000);
            if (rows[i].ctl != 8'h00) xfer(1'b1, 12'h608, {24'h0, rows[i].ctl});
            pulse(0, rows[i].e1, rows[i].lst);
            pulse(0, rows[i].e2, rows[i].lst);
            pulse(0, 7'h00, 1'b0);
            repeat (3) @(posedge ref_clk);
            chk({31'h0, irq}, 32'h1);
            rd(12'h504, rows[i].exp);
            rd(12'h600, 32'h1);
            rd(12'h600, 32'h0);
            $display("row %0d done", i);
        end
        xfer(1'b1, 12'h604, 32'h0);
        xfer(1'b1, 12'h608, 32'h2);
        repeat (3) @(posedge ref_clk);
        ev[1].src_valid <= 1'b1;
        ev[1].src_high <= 32'h89abcdef;
        pulse(1, 7'h28, 1'b0);
        pulse(1, 7'h00, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        rd(12'h588, 32'h89abcdef);
        rd(12'h584, 32'h10020000);
        rd(12'h504, 32'h04000000);
        rd(12'h600, 32'h2);
        xfer(1'b1, 12'h608, 32'h1);
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b0;
        @(posedge ref_clk);
        resetn <= 1'b1;
        rd(12'h504, 32'h0);
        $display("hand tests done");
        tally_and_finish();
    end
endmodule
